// file: pkg/pds_pkg.sv
// constants shared by the programmable decode and standby block
package pds_pkg;
  // input vector layout seen by every product term
  localparam int ADDR_W = 16;
  localparam int CTRL_W = 5;
  localparam int PAGE_W = 8;
  localparam int INCELL_W = 24;
  localparam int OUTCELL_W = 16;
  localparam int ADDR_POS = 0;
  localparam int CTRL_POS = ADDR_POS + ADDR_W;
  localparam int PAGE_POS = CTRL_POS + CTRL_W;
  localparam int INCELL_POS = PAGE_POS + PAGE_W;
  localparam int FB_POS = INCELL_POS + INCELL_W;
  localparam int IN_W = FB_POS + OUTCELL_W;

  // decode array term map
  localparam int MAIN_SEL_N = 8;
  localparam int BOOT_SEL_N = 4;
  localparam int PERIPH_SEL_N = 2;
  localparam int SEL_PT = 3;
  localparam int MAIN_PT_BASE = 0;
  localparam int BOOT_PT_BASE = MAIN_PT_BASE + MAIN_SEL_N * SEL_PT;
  localparam int SRAM_PT_BASE = BOOT_PT_BASE + BOOT_SEL_N * SEL_PT;
  localparam int CFG_PT = SRAM_PT_BASE + SEL_PT;
  localparam int JTAG_PT = CFG_PT + 1;
  localparam int PERIPH_PT_BASE = JTAG_PT + 1;
  localparam int DEC_PT_N = PERIPH_PT_BASE + PERIPH_SEL_N;

  // general array term map
  localparam int GEN_PT_N = 196;
  localparam int EXT_CS_N = 8;
  localparam int CELL_PT = 11;
  localparam int CS_PT = 2;
  localparam int CLR_PT = 2;
  localparam int CELL_GRP_N = 2;
  localparam int CELL_PT_BASE = DEC_PT_N;
  localparam int CS_PT_BASE = CELL_PT_BASE + OUTCELL_W * CELL_PT;
  localparam int CLR_PT_BASE = CS_PT_BASE + EXT_CS_N * CS_PT;
  localparam int PT_TOTAL = DEC_PT_N + GEN_PT_N;
  localparam int PT_IDX_W = 8;

  // power control bits
  localparam int TURBO_BIT = 3;

  // standby idle time
  localparam int IDLE_NS = 70;
  localparam int CLK_PERIOD_NS = 8;
  localparam int IDLE_CYC_INT = (IDLE_NS / CLK_PERIOD_NS < 1) ? 1 : IDLE_NS / CLK_PERIOD_NS;
  localparam int IDLE_W = 4;
  localparam logic [IDLE_W-1:0] IDLE_CYC = IDLE_CYC_INT[IDLE_W-1:0];

  // readback selector codes
  localparam logic [2:0] RD_CELL_A = 3'h0;
  localparam logic [2:0] RD_CELL_B = 3'h1;
  localparam logic [2:0] RD_IN_0 = 3'h2;
  localparam logic [2:0] RD_IN_1 = 3'h3;
  localparam logic [2:0] RD_IN_2 = 3'h4;

  // reset values
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [OUTCELL_W-1:0] CELL_RST = 16'h0000;
endpackage

// file: rtl/pds_term.sv
// one programmable product term with its own mask storage
`timescale 1ns/1ps
`default_nettype none
module pds_term #(
  parameter int IN_W = 69,
  parameter int IDX_W = 8,
  parameter logic [IDX_W-1:0] MY_IDX = '0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic prog_we_i,
  input wire logic [IDX_W-1:0] prog_idx_i,
  input wire logic prog_on_i,
  input wire logic [IN_W-1:0] prog_care_i,
  input wire logic [IN_W-1:0] prog_val_i,
  input wire logic [IN_W-1:0] in_vec_i,
  output logic hit_o
);
  logic on_q;
  logic [IN_W-1:0] care_q;
  logic [IN_W-1:0] val_q;

  // mask storage, cleared to an unused term at reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      on_q <= 1'b0;
      care_q <= '0;
      val_q <= '0;
    end else if (prog_we_i && prog_idx_i == MY_IDX) begin
      on_q <= prog_on_i;
      care_q <= prog_care_i;
      val_q <= prog_val_i;
    end
  end

  // and of the cared inputs, each in true or complement form
  assign hit_o = on_q && (((in_vec_i ^ val_q) & care_q) == '0);
endmodule
`default_nettype wire

// file: rtl/pds_pld_top.sv
// decode array, general logic array and automatic standby
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Fast mode off: the arrays idle after about 70 ns of unchanged inputs, wake on change.
// - Fast mode is bit 3 of power control register zero; clearing it allows standby.
// - Five bits of power control register two each keep one microcontroller control signal out of the arrays.
// - Eight main flash sector selects are each the or of up to three product terms.
// - Four boot flash sector selects are each the or of up to three product terms.
// - One SRAM select is the or of up to three product terms.
// - One select enables access to the configuration register space.
// - One JTAG select enables the in-system programming port on port E.
// - Two peripheral selects serve ports in peripheral I/O mode.
// - The general array drives eight dedicated chip selects without using any output cell.
// - The general array has 24 input cells and 16 output cells, each usable as a chip select.
// - The general array and-plane forms up to 196 terms for output cells and chip selects.
// - The microcontroller loads output cells and reads input and output cells directly.
// - The eight page select bits are inputs to both arrays.
// - An output cell load happens at the write strobe's trailing edge and overrides own logic.
module pds_pld_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [pds_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pds_pkg::CTRL_W-1:0] ctrl_i,
  input wire logic [pds_pkg::PAGE_W-1:0] page_select_bits_i,
  input wire logic [pds_pkg::INCELL_W-1:0] input_cell_pins_i,
  input wire logic [7:0] power_ctrl_reg_zero_i,
  input wire logic [pds_pkg::CTRL_W-1:0] power_ctrl_reg_two_i,
  input wire logic prog_we_i,
  input wire logic [pds_pkg::PT_IDX_W-1:0] prog_idx_i,
  input wire logic prog_on_i,
  input wire logic [pds_pkg::IN_W-1:0] prog_care_i,
  input wire logic [pds_pkg::IN_W-1:0] prog_val_i,
  input wire logic cell_wr_i,
  input wire logic cell_grp_i,
  input wire logic [7:0] cell_wdata_i,
  input wire logic [2:0] cell_rd_sel_i,
  output logic [pds_pkg::MAIN_SEL_N-1:0] main_flash_sel_o,
  output logic [pds_pkg::BOOT_SEL_N-1:0] boot_flash_sel_o,
  output logic sram_sel_o,
  output logic config_space_select_o,
  output logic jtag_sel_o,
  output logic [pds_pkg::PERIPH_SEL_N-1:0] periph_sel_o,
  output logic [pds_pkg::EXT_CS_N-1:0] ext_cs_o,
  output logic [pds_pkg::OUTCELL_W-1:0] output_cell_o,
  output logic [7:0] cell_rdata_o,
  output logic standby_o
);
  import pds_pkg::*;

  logic [CTRL_W-1:0] ctrl_gated;
  logic [INCELL_W-1:0] input_cell_q;
  logic [INCELL_W-1:0] pin_s1_q;
  logic [INCELL_W-1:0] pin_s2_q;
  logic [INCELL_W-1:0] pin_s3_q;
  logic [OUTCELL_W-1:0] cell_q;
  logic [IN_W-1:0] in_now;
  logic [IN_W-1:0] in_q;
  logic in_change;
  logic turbo_on;
  logic [IDLE_W-1:0] idle_q;
  logic standby_q;
  logic [PT_TOTAL-1:0] hit;
  logic [MAIN_SEL_N-1:0] main_sum;
  logic [BOOT_SEL_N-1:0] boot_sum;
  logic [PERIPH_SEL_N-1:0] periph_sum;
  logic [EXT_CS_N-1:0] cs_sum;
  logic [OUTCELL_W-1:0] cell_sum;
  logic [CELL_GRP_N-1:0] clr_sum;
  logic wr_q;
  logic wr_fall;

  // control signals blocked per bit before reaching the arrays
  assign ctrl_gated = ctrl_i & ~power_ctrl_reg_two_i;

  // shared input vector: address, control, page bits, input cells, cell feedback
  assign in_now = {cell_q, input_cell_q, page_select_bits_i, ctrl_gated, addr_i};

  assign turbo_on = power_ctrl_reg_zero_i[TURBO_BIT];
  assign in_change = (in_now != in_q);

  // input cells take a pin change once the second and third stages agree
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      input_cell_q <= '0;
    end else begin
      pin_s1_q <= input_cell_pins_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      input_cell_q <= (pin_s2_q & pin_s3_q) | (input_cell_q & (pin_s2_q | pin_s3_q));
    end
  end

  // evaluation register, frozen while the arrays are in standby
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      in_q <= '0;
    end else if (!standby_q) begin
      in_q <= in_now;
    end
  end

  // idle timer and standby flag
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      idle_q <= '0;
      standby_q <= 1'b0;
    end else if (in_change || turbo_on) begin
      idle_q <= '0;
      standby_q <= 1'b0;
    end else begin
      if (idle_q != IDLE_CYC) begin
        idle_q <= idle_q + 1'b1;
      end
      standby_q <= (idle_q == IDLE_CYC);
    end
  end

  // decode terms followed by general terms, all on the same vector
  for (genvar t = 0; t < PT_TOTAL; t++) begin : g_term
    pds_term #(
      .IN_W(IN_W),
      .IDX_W(PT_IDX_W),
      .MY_IDX(PT_IDX_W'(t))
    ) u_term (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .prog_we_i(prog_we_i),
      .prog_idx_i(prog_idx_i),
      .prog_on_i(prog_on_i),
      .prog_care_i(prog_care_i),
      .prog_val_i(prog_val_i),
      .in_vec_i(in_q),
      .hit_o(hit[t])
    );
  end

  // sums of the decode array
  for (genvar m = 0; m < MAIN_SEL_N; m++) begin : g_main
    assign main_sum[m] = |hit[MAIN_PT_BASE + m * SEL_PT +: SEL_PT];
  end
  for (genvar b = 0; b < BOOT_SEL_N; b++) begin : g_boot
    assign boot_sum[b] = |hit[BOOT_PT_BASE + b * SEL_PT +: SEL_PT];
  end
  for (genvar p = 0; p < PERIPH_SEL_N; p++) begin : g_periph
    assign periph_sum[p] = hit[PERIPH_PT_BASE + p];
  end

  // sums of the general array
  for (genvar c = 0; c < OUTCELL_W; c++) begin : g_cell
    assign cell_sum[c] = |hit[CELL_PT_BASE + c * CELL_PT +: CELL_PT];
  end
  for (genvar s = 0; s < EXT_CS_N; s++) begin : g_cs
    assign cs_sum[s] = |hit[CS_PT_BASE + s * CS_PT +: CS_PT];
  end
  for (genvar g = 0; g < CELL_GRP_N; g++) begin : g_clr
    assign clr_sum[g] = |hit[CLR_PT_BASE + g * CLR_PT +: CLR_PT];
  end

  // decode selects, held while in standby
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      main_flash_sel_o <= '0;
      boot_flash_sel_o <= '0;
      sram_sel_o <= 1'b0;
      config_space_select_o <= 1'b0;
      jtag_sel_o <= 1'b0;
      periph_sel_o <= '0;
    end else if (!standby_q) begin
      main_flash_sel_o <= main_sum;
      boot_flash_sel_o <= boot_sum;
      sram_sel_o <= |hit[SRAM_PT_BASE +: SEL_PT];
      config_space_select_o <= hit[CFG_PT];
      jtag_sel_o <= hit[JTAG_PT];
      periph_sel_o <= periph_sum;
    end
  end

  // dedicated chip selects, independent of the output cells
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ext_cs_o <= '0;
    end else if (!standby_q) begin
      ext_cs_o <= cs_sum;
    end
  end

  // write strobe trailing edge detect
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= cell_wr_i;
    end
  end
  assign wr_fall = wr_q && !cell_wr_i;

  // output cells: load wins over clear, clear over own logic
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cell_q <= CELL_RST;
    end else begin
      for (int g = 0; g < CELL_GRP_N; g++) begin
        if (wr_fall && cell_grp_i == g[0]) begin
          cell_q[g*8 +: 8] <= cell_wdata_i;
        end else if (clr_sum[g]) begin
          cell_q[g*8 +: 8] <= 8'h00;
        end else begin
          cell_q[g*8 +: 8] <= cell_sum[g*8 +: 8];
        end
      end
    end
  end
  assign output_cell_o = cell_q;

  // direct readback of input and output cells
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cell_rdata_o <= RDATA_RST;
    end else begin
      unique case (cell_rd_sel_i)
        RD_CELL_A: cell_rdata_o <= cell_q[7:0];
        RD_CELL_B: cell_rdata_o <= cell_q[15:8];
        RD_IN_0: cell_rdata_o <= input_cell_q[7:0];
        RD_IN_1: cell_rdata_o <= input_cell_q[15:8];
        RD_IN_2: cell_rdata_o <= input_cell_q[23:16];
        default: cell_rdata_o <= RDATA_RST;
      endcase
    end
  end

  assign standby_o = standby_q;
endmodule
`default_nettype wire

// file: verification/pds_pld_props.sv
// checker for the decode and standby block
`timescale 1ns/1ps
`default_nettype none
module pds_pld_props (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [pds_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pds_pkg::PAGE_W-1:0] page_select_bits_i,
  input wire logic [pds_pkg::INCELL_W-1:0] input_cell_pins_i,
  input wire logic [7:0] power_ctrl_reg_zero_i,
  input wire logic [pds_pkg::CTRL_W-1:0] power_ctrl_reg_two_i,
  input wire logic cell_wr_i,
  input wire logic cell_grp_i,
  input wire logic [7:0] cell_wdata_i,
  input wire logic [2:0] cell_rd_sel_i,
  input wire logic [pds_pkg::MAIN_SEL_N-1:0] main_flash_sel_o,
  input wire logic [pds_pkg::EXT_CS_N-1:0] ext_cs_o,
  input wire logic [pds_pkg::OUTCELL_W-1:0] output_cell_o,
  input wire logic [7:0] cell_rdata_o,
  input wire logic standby_o
);
  import pds_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_fast_no_sleep: assert property (power_ctrl_reg_zero_i[TURBO_BIT] |=> !standby_o)
    else $error("standby in fast mode");
  a_wake_on_addr: assert property (standby_o && $changed(addr_i) |=> !standby_o)
    else $error("no wake on address change");
  a_idle_before_sleep: assert property ($rose(standby_o) |-> $past(addr_i, 8) == addr_i)
    else $error("standby too early");
  a_hold_in_sleep: assert property (standby_o && $past(standby_o) |->
    $stable(main_flash_sel_o) && $stable(ext_cs_o))
    else $error("selects moved in standby");
  a_masked_ctrl_quiet: assert property (standby_o && power_ctrl_reg_two_i == 5'h1F
    && !power_ctrl_reg_zero_i[TURBO_BIT] && $stable(addr_i) && $stable(page_select_bits_i)
    && $stable(input_cell_pins_i) && $stable(power_ctrl_reg_two_i) |=> standby_o)
    else $error("masked control woke arrays");
  a_cell_load: assert property ($fell(cell_wr_i) |=>
    ($past(cell_grp_i) ? output_cell_o[15:8] : output_cell_o[7:0]) == $past(cell_wdata_i))
    else $error("cell load lost");
  a_read_cells_b: assert property (cell_rd_sel_i == RD_CELL_B |=>
    cell_rdata_o == $past(output_cell_o[15:8]))
    else $error("cell readback wrong");
  a_read_unused: assert property (cell_rd_sel_i > RD_IN_2 |=> cell_rdata_o == 8'h00)
    else $error("unused readback not zero");
  c_sleep: cover property ($rose(standby_o));
  c_load: cover property ($fell(cell_wr_i));
  c_wake: cover property ($fell(standby_o));
endmodule
bind pds_pld_top pds_pld_props pds_pld_props_i (.clk_i, .reset_i, .addr_i,
  .page_select_bits_i, .input_cell_pins_i, .power_ctrl_reg_zero_i, .power_ctrl_reg_two_i,
  .cell_wr_i, .cell_grp_i, .cell_wdata_i, .cell_rd_sel_i, .main_flash_sel_o, .ext_cs_o,
  .output_cell_o, .cell_rdata_o, .standby_o);
`default_nettype wire

// file: verification/pds_mcu_model.sv
// microcontroller bus model for the decode block
`timescale 1ns/1ps
`default_nettype none
module pds_mcu_model (
  input wire logic clk_i,
  output logic [15:0] addr_o,
  output logic [4:0] ctrl_o,
  output logic [7:0] page_o,
  output logic cell_wr_o,
  output logic cell_grp_o,
  output logic [7:0] cell_wdata_o
);
  initial begin
    addr_o = 16'h0000;
    ctrl_o = 5'h00;
    page_o = 8'h00;
    cell_wr_o = 1'b0;
    cell_grp_o = 1'b0;
    cell_wdata_o = 8'h00;
  end
  // address, control and page bits
  task automatic bus(input logic [15:0] a, input logic [4:0] c, input logic [7:0] p);
    @(posedge clk_i);
    addr_o <= a;
    ctrl_o <= c;
    page_o <= p;
  endtask
  // strobe one cycle high, data held through the trailing edge
  task automatic cell_load(input logic g, input logic [7:0] d);
    @(posedge clk_i);
    cell_wr_o <= 1'b1;
    cell_grp_o <= g;
    cell_wdata_o <= d;
    @(posedge clk_i);
    cell_wr_o <= 1'b0;
    @(posedge clk_i);
    cell_wdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the decode and standby block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module testbench;
  import pds_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] addr_i;
  logic [4:0] ctrl_i;
  logic [7:0] page_select_bits_i;
  logic cell_wr_i, cell_grp_i;
  logic [7:0] cell_wdata_i, cell_rdata_o;
  logic [23:0] input_cell_pins_i = 24'h123456;
  logic [7:0] power_ctrl_reg_zero_i = 8'h08;
  logic [4:0] power_ctrl_reg_two_i = 5'h00;
  logic prog_we_i = 1'b0;
  logic prog_on_i = 1'b0;
  logic [7:0] prog_idx_i = 8'h00;
  logic [IN_W-1:0] prog_care_i = '0, prog_val_i = '0;
  logic [2:0] cell_rd_sel_i = 3'h0;
  logic [7:0] main_flash_sel_o, ext_cs_o;
  logic [3:0] boot_flash_sel_o;
  logic [1:0] periph_sel_o;
  logic sram_sel_o, config_space_select_o, jtag_sel_o, standby_o;
  logic [15:0] output_cell_o;
  int n_errors = 0;
  int checks = 0;
  wire [24:0] sel = {ext_cs_o, periph_sel_o, jtag_sel_o, config_space_select_o,
    sram_sel_o, boot_flash_sel_o, main_flash_sel_o};
  pds_pld_top pds_pld_top_i (.clk_i, .reset_i, .addr_i, .ctrl_i, .page_select_bits_i,
    .input_cell_pins_i, .power_ctrl_reg_zero_i, .power_ctrl_reg_two_i, .prog_we_i,
    .prog_idx_i, .prog_on_i, .prog_care_i, .prog_val_i, .cell_wr_i, .cell_grp_i,
    .cell_wdata_i, .cell_rd_sel_i, .main_flash_sel_o, .boot_flash_sel_o, .sram_sel_o,
    .config_space_select_o, .jtag_sel_o, .periph_sel_o, .ext_cs_o, .output_cell_o,
    .cell_rdata_o, .standby_o);
  pds_mcu_model pds_mcu_model_i (.clk_i, .addr_o(addr_i), .ctrl_o(ctrl_i),
    .page_o(page_select_bits_i), .cell_wr_o(cell_wr_i), .cell_grp_o(cell_grp_i),
    .cell_wdata_o(cell_wdata_i));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic prog(input int i, input logic [IN_W-1:0] c, input logic [IN_W-1:0] v);
    @(posedge clk_i);
    prog_we_i <= 1'b1;
    prog_on_i <= 1'b1;
    prog_idx_i <= i[7:0];
    prog_care_i <= c;
    prog_val_i <= v;
    @(posedge clk_i);
    prog_we_i <= 1'b0;
  endtask
  // first, second or third term of select k in output order
  function automatic int tidx(input int k);
    if (k < 8) return 3 * k + k % 3;
    if (k < 12) return 24 + 3 * (k - 8) + k % 3;
    if (k < 13) return 36;
    if (k < 17) return k + 26;
    return 220 + 2 * (k - 17);
  endfunction
  task automatic results;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    n_errors++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    wt(1);
    `CHK("reset sel", 25'h0, sel)
    for (int k = 0; k < 25; k++) prog(tidx(k), 69'hFFFF, 69'h0100 + k);
    prog(1, 69'hFF << PAGE_POS, 69'hA5 << PAGE_POS);
    prog(37, 69'h4FFFF, 69'h4FFFF);
    prog(43, 69'h0, 69'h0);
    for (int k = 0; k < 25; k++) begin
      pds_mcu_model_i.bus(16'h0100 + k[15:0], 5'h00, 8'h00);
      wt(2);
      `CHK("select", 25'h1 << k, sel)
    end
    pds_mcu_model_i.bus(16'h0000, 5'h00, 8'hA5);
    wt(2);
    `CHK("page", 25'h1, sel)
    pds_mcu_model_i.bus(16'hFFFF, 5'h04, 8'h00);
    wt(2);
    `CHK("ctrl", 25'h1000, sel)
    @(posedge clk_i);
    power_ctrl_reg_two_i <= 5'h04;
    wt(2);
    `CHK("ctrl masked", 25'h0, sel)
    pds_mcu_model_i.cell_load(1'b0, 8'hA4);
    #1;
    `CHK("cell A", 8'hA4, output_cell_o[7:0])
    wt(1);
    `CHK("cell A term", 8'h01, output_cell_o[7:0])
    `CHK("read A", 8'hA4, cell_rdata_o)
    @(posedge clk_i);
    cell_rd_sel_i <= RD_CELL_B;
    pds_mcu_model_i.cell_load(1'b1, 8'h3C);
    #1;
    `CHK("cell B", 8'h3C, output_cell_o[15:8])
    wt(1);
    `CHK("read B", 8'h3C, cell_rdata_o)
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      cell_rd_sel_i <= RD_IN_0 + i[2:0];
      wt(2);
      `CHK("read in", i < 3 ? 8'(24'h123456 >> 8 * i) : 8'h00, cell_rdata_o)
    end
    @(posedge clk_i);
    power_ctrl_reg_two_i <= 5'h1F;
    power_ctrl_reg_zero_i <= 8'h00;
    wt(7);
    `CHK("awake", 1'b0, standby_o)
    wt(5);
    `CHK("asleep", 1'b1, standby_o)
    pds_mcu_model_i.bus(16'hFFFF, 5'h1F, 8'h00);
    wt(2);
    `CHK("masked ctrl", 1'b1, standby_o)
    pds_mcu_model_i.bus(16'h0105, 5'h00, 8'h00);
    wt(1);
    `CHK("wake", 1'b0, standby_o)
    wt(2);
    `CHK("late sel", 25'h20, sel)
    @(posedge clk_i);
    power_ctrl_reg_zero_i <= 8'h08;
    wt(12);
    `CHK("fast", 1'b0, standby_o)
    results();
  end
endmodule
`default_nettype wire
